// [shared/dtd_pkg.sv]
package dtd_pkg;

  // counts are in processor clocks, one per rising i_clock edge
  localparam int CNT_W = 5;

  // opcode patterns, compared against the upper opcode bits; OPC_PUSH_SEG_LO and OPC_POP_SEG_LO against the low three
  localparam logic [6:0] OPC_MOV_REG_RM = 7'h44; // 1000100w
  localparam logic [6:0] OPC_MOV_RM_REG = 7'h45; // 1000101w
  localparam logic [6:0] OPC_MOV_IMM_RM = 7'h63; // 1100011w
  localparam logic [3:0] OPC_MOV_IMM_REG = 4'hb; // 1011wrrr
  localparam logic [6:0] OPC_MOV_MEM_ACC = 7'h50; // 1010000w
  localparam logic [6:0] OPC_MOV_ACC_MEM = 7'h51; // 1010001w
  localparam logic [7:0] OPC_SEG_LOAD = 8'h8e;
  localparam logic [7:0] OPC_SEG_STORE = 8'h8c;
  localparam logic [7:0] OPC_PUSH_MEM = 8'hff; // reg field 110
  localparam logic [2:0] SUB_PUSH_MEM = 3'h6;
  localparam logic [4:0] OPC_PUSH_REG = 5'h0a;
  localparam logic [2:0] OPC_PUSH_SEG_LO = 3'h6; // 000ss110
  localparam logic [7:0] OPC_PUSH_ALL = 8'h60;
  localparam logic [7:0] OPC_POP_MEM = 8'h8f; // reg field 000
  localparam logic [2:0] SUB_POP_MEM = 3'h0;
  localparam logic [4:0] OPC_POP_REG = 5'h0b;
  localparam logic [2:0] OPC_POP_SEG_LO = 3'h7; // 000ss111
  localparam logic [1:0] SEG_CODE = 2'h1; // not a legal pop target
  localparam logic [7:0] OPC_POP_ALL = 8'h61;
  localparam logic [6:0] OPC_XCHG_RM = 7'h43; // 1000011w
  localparam logic [4:0] OPC_XCHG_ACC = 5'h12;
  localparam logic [6:0] OPC_IN_FIXED = 7'h72;
  localparam logic [6:0] OPC_IN_VAR = 7'h76;
  localparam logic [6:0] OPC_OUT_FIXED = 7'h73;
  localparam logic [6:0] OPC_OUT_VAR = 7'h77;
  localparam logic [7:0] OPC_TABLE_LOOKUP = 8'hd7;
  localparam logic [1:0] MOD_REGISTER = 2'h3;

  // clock counts: register form / memory form, real and protected mode
  localparam logic [4:0] CLK_MOV_STORE_R = 5'h02;
  localparam logic [4:0] CLK_MOV_STORE_M = 5'h03;
  localparam logic [4:0] CLK_MOV_LOAD_M = 5'h05;
  localparam logic [4:0] CLK_SEG_LOAD_PR = 5'h11; // 17
  localparam logic [4:0] CLK_SEG_LOAD_PM = 5'h13; // 19
  localparam logic [4:0] CLK_PUSH = 5'h03;
  localparam logic [4:0] CLK_POP = 5'h05;
  localparam logic [4:0] CLK_POP_SEG_P = 5'h14; // 20
  localparam logic [4:0] CLK_PUSH_ALL = 5'h11; // 17
  localparam logic [4:0] CLK_POP_ALL = 5'h13; // 19
  localparam logic [4:0] CLK_XCHG_R = 5'h03;
  localparam logic [4:0] CLK_XCHG_M = 5'h05;
  localparam logic [4:0] CLK_IN = 5'h05;
  localparam logic [4:0] CLK_OUT = 5'h03;
  localparam logic [4:0] CLK_TABLE_LOOKUP = 5'h05;
  localparam logic [4:0] CLK_EFF_ADDR = 5'h03;
  localparam logic [4:0] CLK_PTR_LOAD_R = 5'h07;
  localparam logic [4:0] CLK_PTR_LOAD_P = 5'h15; // 21
  localparam logic [4:0] CLK_THREE_ELEM = 5'h01;

  // faults
  localparam logic [7:0] VEC_SEG_OVERRUN = 8'h0d; // 13
  localparam logic [15:0] OFFSET_LAST = 16'hffff;

  typedef enum logic [4:0] {
    DTD_OP_NONE = 5'h00,
    DTD_OP_TRANSFER = 5'h01,
    DTD_OP_TRANSFER_IMM = 5'h02,
    DTD_OP_TRANSFER_ACC = 5'h03,
    DTD_OP_SEG_LOAD = 5'h04,
    DTD_OP_SEG_STORE = 5'h05,
    DTD_OP_PUSH = 5'h06,
    DTD_OP_POP = 5'h07,
    DTD_OP_PUSH_ALL = 5'h08,
    DTD_OP_POP_ALL = 5'h09,
    DTD_OP_EXCHANGE = 5'h0a,
    DTD_OP_PORT_IN = 5'h0b,
    DTD_OP_PORT_OUT = 5'h0c,
    DTD_OP_TABLE_LOOKUP = 5'h0d,
    DTD_OP_EFFECTIVE_ADDRESS = 5'h0e,
    DTD_OP_POINTER_LOAD_FIRST = 5'h0f,
    DTD_OP_POINTER_LOAD_EXTRA = 5'h10
  } dtd_op_t;

  typedef enum logic [1:0] {
    DTD_ST_IDLE = 2'b01,
    DTD_ST_EXEC = 2'b10
  } dtd_state_t;

  // operand source that writes the destination register
  typedef enum logic [1:0] {
    DTD_WB_NONE = 2'h0,
    DTD_WB_OPERAND = 2'h1,
    DTD_WB_OFFSET = 2'h2,
    DTD_WB_TABLE_BYTE = 2'h3
  } dtd_wb_t;

  typedef struct packed {
    dtd_op_t op;
    logic word;
    logic reg_is_dest;
    logic mem_operand;
    logic [1:0] seg_sel;
    logic [2:0] reg_sel;
    logic [2:0] rm_sel;
    dtd_wb_t writeback;
    logic [4:0] clocks;
  } dtd_decode_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] modrm;
    logic [15:0] ea_offset;
    logic three_elem;
  } dtd_request_t;

endpackage

// [hw/dtd_cycle_counter.sv]
`timescale 1ns/100ps
// counts an execution down from its loaded clock count
module dtd_cycle_counter #(
  parameter int WIDTH = 5
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_value,
  output logic o_last
);

  logic [WIDTH-1:0] count_ff;

  // a load always wins over counting, so back-to-back work never slips
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      count_ff <= '0;
    end else if (i_load) begin
      count_ff <= i_value;
    end else if (count_ff != '0) begin
      count_ff <= count_ff - WIDTH'(1);
    end
  end

  assign o_last = (count_ff == WIDTH'(1));

endmodule

// [hw/dtd_decoder.sv]
`timescale 1ns/100ps
// What this block does
// [RULE_01] opcode 8e loads a segment register; 2/5 real, 17/19 protected
// [RULE_02] opcode 8c stores a segment register; 2 register, 3 memory
// [RULE_03] opcode d7 replaces low accumulator byte by table byte; 5 clocks
// [RULE_04] effective address load writes the offset itself; 3 clocks
// [RULE_05] pointer load into data segment needs memory; 7 real, 21 protected
// [RULE_06] pointer load into extra segment: offset and selector; 7 / 21
// [RULE_07] low opcode size bit set means word, clear means byte
// [RULE_08] direction bit set makes register field the destination
// [RULE_09] of two counts, the smaller is register form, larger memory form
// [RULE_10] real mode word access at offset ffff raises fault 13 instead
module dtd_decoder #(
  parameter logic [7:0] OPC_EFFECTIVE_ADDRESS = 8'h8d,
  parameter logic [7:0] OPC_POINTER_LOAD_FIRST = 8'hc5,
  parameter logic [7:0] OPC_POINTER_LOAD_EXTRA = 8'hc4
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_valid,
  input wire dtd_pkg::dtd_request_t i_request,
  input wire logic i_protected,
  output logic o_ready,
  output dtd_pkg::dtd_decode_t o_decode,
  output logic o_busy,
  output logic o_done,
  output logic o_fault,
  output logic [7:0] o_fault_vector,
  output logic o_undefined
);

  dtd_pkg::dtd_state_t state_ff;
  dtd_pkg::dtd_decode_t dec;
  dtd_pkg::dtd_decode_t decode_ff;
  logic fault_ff;
  logic [7:0] fault_vector_ff;
  logic undefined_ff;
  logic done_ff;
  logic accept;
  logic start;
  logic overrun;
  logic bad_form;
  logic last;
  logic [7:0] opc;
  logic [1:0] mod_f;
  logic [2:0] reg_f;
  logic is_mem;

  assign opc = i_request.opcode;
  assign mod_f = i_request.modrm[7:6];
  assign reg_f = i_request.modrm[5:3];
  assign is_mem = (mod_f != dtd_pkg::MOD_REGISTER);

  // pick register or memory count from the addressing form
  function automatic logic [4:0] pick(input logic mem,
                                      input logic [4:0] r_cnt,
                                      input logic [4:0] m_cnt);
    pick = mem ? m_cnt : r_cnt; // RULE_09
  endfunction

  // opcode decode; only the data transfer group is recognised here
  always_comb begin
    dec = '0;
    dec.op = dtd_pkg::DTD_OP_NONE;
    dec.writeback = dtd_pkg::DTD_WB_NONE;
    dec.reg_sel = reg_f;
    dec.rm_sel = i_request.modrm[2:0];
    dec.seg_sel = reg_f[1:0];
    dec.word = opc[0]; // RULE_07
    bad_form = 1'b0;
    if (opc[7:1] == dtd_pkg::OPC_MOV_REG_RM ||
        opc[7:1] == dtd_pkg::OPC_MOV_RM_REG) begin
      dec.op = dtd_pkg::DTD_OP_TRANSFER;
      dec.reg_is_dest = opc[1]; // RULE_08
      dec.mem_operand = is_mem;
      dec.writeback = dtd_pkg::DTD_WB_OPERAND;
      dec.clocks = pick(is_mem, dtd_pkg::CLK_MOV_STORE_R,
                        opc[1] ? dtd_pkg::CLK_MOV_LOAD_M
                               : dtd_pkg::CLK_MOV_STORE_M); // RULE_09
    end else if (opc[7:1] == dtd_pkg::OPC_MOV_IMM_RM) begin
      dec.op = dtd_pkg::DTD_OP_TRANSFER_IMM;
      dec.mem_operand = is_mem;
      dec.clocks = pick(is_mem, dtd_pkg::CLK_MOV_STORE_R,
                        dtd_pkg::CLK_MOV_STORE_M);
    end else if (opc[7:4] == dtd_pkg::OPC_MOV_IMM_REG) begin
      // immediate to register carries its size bit higher up
      dec.op = dtd_pkg::DTD_OP_TRANSFER_IMM;
      dec.word = opc[3]; // RULE_07
      dec.reg_is_dest = 1'b1;
      dec.reg_sel = opc[2:0];
      dec.writeback = dtd_pkg::DTD_WB_OPERAND;
      dec.clocks = dtd_pkg::CLK_MOV_STORE_R;
    end else if (opc[7:1] == dtd_pkg::OPC_MOV_MEM_ACC ||
                 opc[7:1] == dtd_pkg::OPC_MOV_ACC_MEM) begin
      dec.op = dtd_pkg::DTD_OP_TRANSFER_ACC;
      dec.mem_operand = 1'b1;
      dec.reg_is_dest = ~opc[1];
      dec.reg_sel = 3'h0;
      dec.writeback = opc[1] ? dtd_pkg::DTD_WB_NONE : dtd_pkg::DTD_WB_OPERAND;
      dec.clocks = opc[1] ? dtd_pkg::CLK_MOV_STORE_M : dtd_pkg::CLK_MOV_LOAD_M;
    end else if (opc == dtd_pkg::OPC_SEG_LOAD) begin
      dec.op = dtd_pkg::DTD_OP_SEG_LOAD; // RULE_01
      dec.word = 1'b1;
      dec.reg_is_dest = 1'b1;
      dec.mem_operand = is_mem;
      dec.writeback = dtd_pkg::DTD_WB_OPERAND;
      dec.clocks = i_protected
        ? pick(is_mem, dtd_pkg::CLK_SEG_LOAD_PR, dtd_pkg::CLK_SEG_LOAD_PM)
        : pick(is_mem, dtd_pkg::CLK_MOV_STORE_R,
               dtd_pkg::CLK_MOV_LOAD_M); // RULE_01
    end else if (opc == dtd_pkg::OPC_SEG_STORE) begin
      dec.op = dtd_pkg::DTD_OP_SEG_STORE; // RULE_02
      dec.word = 1'b1;
      dec.mem_operand = is_mem;
      dec.writeback = dtd_pkg::DTD_WB_OPERAND;
      dec.clocks = pick(is_mem, dtd_pkg::CLK_MOV_STORE_R,
                        dtd_pkg::CLK_MOV_STORE_M); // RULE_02
    end else if (opc == dtd_pkg::OPC_PUSH_MEM &&
                 reg_f == dtd_pkg::SUB_PUSH_MEM) begin
      dec.op = dtd_pkg::DTD_OP_PUSH;
      dec.word = 1'b1;
      dec.mem_operand = is_mem;
      dec.clocks = dtd_pkg::CLK_POP;
    end else if (opc == dtd_pkg::OPC_POP_MEM &&
                 reg_f == dtd_pkg::SUB_POP_MEM) begin
      dec.op = dtd_pkg::DTD_OP_POP;
      dec.word = 1'b1;
      dec.mem_operand = is_mem;
      dec.clocks = dtd_pkg::CLK_POP;
    end else if (opc[7:3] == dtd_pkg::OPC_PUSH_REG ||
                 opc[7:3] == dtd_pkg::OPC_POP_REG) begin
      dec.op = opc[3] ? dtd_pkg::DTD_OP_POP : dtd_pkg::DTD_OP_PUSH;
      dec.word = 1'b1;
      dec.reg_is_dest = opc[3];
      dec.reg_sel = opc[2:0];
      dec.writeback = opc[3] ? dtd_pkg::DTD_WB_OPERAND : dtd_pkg::DTD_WB_NONE;
      dec.clocks = opc[3] ? dtd_pkg::CLK_POP : dtd_pkg::CLK_PUSH;
    end else if (opc[7:5] == 3'h0 &&
                 opc[2:0] == dtd_pkg::OPC_PUSH_SEG_LO) begin
      dec.op = dtd_pkg::DTD_OP_PUSH;
      dec.word = 1'b1;
      dec.seg_sel = opc[4:3];
      dec.clocks = dtd_pkg::CLK_PUSH;
    end else if (opc[7:5] == 3'h0 && opc[2:0] == dtd_pkg::OPC_POP_SEG_LO &&
                 opc[4:3] != dtd_pkg::SEG_CODE) begin
      // the code segment cannot be popped; that code stays undecoded
      dec.op = dtd_pkg::DTD_OP_POP;
      dec.word = 1'b1;
      dec.reg_is_dest = 1'b1;
      dec.seg_sel = opc[4:3];
      dec.clocks = i_protected ? dtd_pkg::CLK_POP_SEG_P : dtd_pkg::CLK_POP;
    end else if (opc == dtd_pkg::OPC_PUSH_ALL ||
                 opc == dtd_pkg::OPC_POP_ALL) begin
      dec.op = opc[0] ? dtd_pkg::DTD_OP_POP_ALL : dtd_pkg::DTD_OP_PUSH_ALL;
      dec.word = 1'b1;
      dec.clocks = opc[0] ? dtd_pkg::CLK_POP_ALL : dtd_pkg::CLK_PUSH_ALL;
    end else if (opc[7:1] == dtd_pkg::OPC_XCHG_RM) begin
      dec.op = dtd_pkg::DTD_OP_EXCHANGE;
      dec.reg_is_dest = 1'b1;
      dec.mem_operand = is_mem;
      dec.writeback = dtd_pkg::DTD_WB_OPERAND;
      dec.clocks = pick(is_mem, dtd_pkg::CLK_XCHG_R, dtd_pkg::CLK_XCHG_M);
    end else if (opc[7:3] == dtd_pkg::OPC_XCHG_ACC) begin
      dec.op = dtd_pkg::DTD_OP_EXCHANGE;
      dec.word = 1'b1;
      dec.reg_is_dest = 1'b1;
      dec.reg_sel = opc[2:0];
      dec.writeback = dtd_pkg::DTD_WB_OPERAND;
      dec.clocks = dtd_pkg::CLK_XCHG_R;
    end else if (opc[7:1] == dtd_pkg::OPC_IN_FIXED ||
                 opc[7:1] == dtd_pkg::OPC_IN_VAR) begin
      dec.op = dtd_pkg::DTD_OP_PORT_IN;
      dec.reg_is_dest = 1'b1;
      dec.reg_sel = 3'h0;
      dec.writeback = dtd_pkg::DTD_WB_OPERAND;
      dec.clocks = dtd_pkg::CLK_IN;
    end else if (opc[7:1] == dtd_pkg::OPC_OUT_FIXED ||
                 opc[7:1] == dtd_pkg::OPC_OUT_VAR) begin
      dec.op = dtd_pkg::DTD_OP_PORT_OUT;
      dec.reg_sel = 3'h0;
      dec.clocks = dtd_pkg::CLK_OUT;
    end else if (opc == dtd_pkg::OPC_TABLE_LOOKUP) begin
      dec.op = dtd_pkg::DTD_OP_TABLE_LOOKUP; // RULE_03
      dec.word = 1'b0;
      dec.reg_is_dest = 1'b1;
      dec.reg_sel = 3'h0; // low_accumulator_byte
      dec.writeback = dtd_pkg::DTD_WB_TABLE_BYTE; // RULE_03
      dec.clocks = dtd_pkg::CLK_TABLE_LOOKUP; // RULE_03
    end else if (opc == OPC_EFFECTIVE_ADDRESS) begin
      dec.op = dtd_pkg::DTD_OP_EFFECTIVE_ADDRESS;
      dec.word = 1'b1;
      dec.reg_is_dest = 1'b1;
      dec.writeback = dtd_pkg::DTD_WB_OFFSET; // RULE_04
      dec.clocks = dtd_pkg::CLK_EFF_ADDR; // RULE_04
    end else if (opc == OPC_POINTER_LOAD_FIRST ||
                 opc == OPC_POINTER_LOAD_EXTRA) begin
      dec.op = (opc == OPC_POINTER_LOAD_FIRST)
               ? dtd_pkg::DTD_OP_POINTER_LOAD_FIRST
               : dtd_pkg::DTD_OP_POINTER_LOAD_EXTRA;
      dec.word = 1'b1;
      dec.reg_is_dest = 1'b1;
      dec.mem_operand = 1'b1;
      dec.writeback = dtd_pkg::DTD_WB_OPERAND; // RULE_06
      bad_form = ~is_mem; // RULE_05
      dec.clocks = i_protected ? dtd_pkg::CLK_PTR_LOAD_P
                               : dtd_pkg::CLK_PTR_LOAD_R; // RULE_05 RULE_06
    end
    // offsets summed from three parts cost one more clock
    // the address load sums its offset too, though it never reads memory
    if ((dec.mem_operand ||
         (dec.op == dtd_pkg::DTD_OP_EFFECTIVE_ADDRESS && is_mem)) && // RULE_04
        i_request.three_elem && dec.op != dtd_pkg::DTD_OP_TRANSFER_ACC) begin
      dec.clocks = dec.clocks + dtd_pkg::CLK_THREE_ELEM;
    end
  end

  // a word reference wrapping the segment end is refused in real mode only
  assign overrun = ~i_protected && dec.word && dec.mem_operand &&
                   i_request.ea_offset == dtd_pkg::OFFSET_LAST; // RULE_10
  assign o_ready = (state_ff == dtd_pkg::DTD_ST_IDLE);
  assign accept = i_valid && o_ready;
  assign start = accept && !overrun && !bad_form &&
                 dec.op != dtd_pkg::DTD_OP_NONE;
  assign o_busy = (state_ff == dtd_pkg::DTD_ST_EXEC);

  dtd_cycle_counter #(
    .WIDTH(dtd_pkg::CNT_W)
  ) u_counter (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_load(start),
    .i_value(dec.clocks),
    .o_last(last)
  );

  // execution sequencing: held busy for exactly the decoded clock count
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= dtd_pkg::DTD_ST_IDLE;
    end else begin
      unique case (state_ff)
        dtd_pkg::DTD_ST_IDLE: begin
          if (start) begin
            state_ff <= dtd_pkg::DTD_ST_EXEC;
          end
        end
        dtd_pkg::DTD_ST_EXEC: begin
          if (last) begin
            state_ff <= dtd_pkg::DTD_ST_IDLE;
          end
        end
      endcase
    end
  end

  // decoded fields stay steady for the whole execution
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      decode_ff <= '0;
    end else if (accept) begin
      decode_ff <= dec;
    end
  end

  // completion and fault pulses, one cycle each
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      done_ff <= 1'b0;
      fault_ff <= 1'b0;
      fault_vector_ff <= 8'h00;
      undefined_ff <= 1'b0;
    end else begin
      done_ff <= o_busy && last;
      fault_ff <= accept && overrun && !bad_form; // RULE_10
      // vector follows the fault pulse exactly, an undefined form wins
      fault_vector_ff <= (accept && overrun && !bad_form)
                         ? dtd_pkg::VEC_SEG_OVERRUN : 8'h00;
      undefined_ff <= accept &&
                      (bad_form || dec.op == dtd_pkg::DTD_OP_NONE); // RULE_05
    end
  end

  assign o_decode = decode_ff;
  assign o_done = done_ff;
  assign o_fault = fault_ff;
  assign o_fault_vector = fault_vector_ff;
  assign o_undefined = undefined_ff;

endmodule

// [verification/dtd_decoder_chk.sv]
`timescale 1ns/100ps
// watches the decoder ports: execution length, faults, decoded counts
module dtd_decoder_chk (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_valid,
  input wire dtd_pkg::dtd_request_t i_request,
  input wire logic i_protected,
  input wire logic o_ready,
  input wire dtd_pkg::dtd_decode_t o_decode,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_fault,
  input wire logic [7:0] o_fault_vector,
  input wire logic o_undefined
);
  logic [5:0] run_ff;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // busy run length; 22 clocks at most, so 6 bits never wrap
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      run_ff <= 6'h00;
    end else begin
      run_ff <= o_busy ? run_ff + 6'h01 : 6'h00;
    end
  end
  // a request taken, and a memory operand with a two-part offset
  sequence s_take;
    i_valid && o_ready;
  endsequence
  sequence s_mem;
    i_request.modrm[7:6] != 2'h3 && !i_request.three_elem;
  endsequence
  a_busy_length: assert property ($fell(o_busy) |->
    run_ff == {1'b0, o_decode.clocks}) else $error("busy length wrong");
  a_done_pulse: assert property (o_done == $fell(o_busy))
    else $error("done not after busy");
  a_fault_vector: assert property (
    o_fault_vector == (o_fault ? 8'h0d : 8'h00)) else $error("bad vector");
  a_overrun_refused: assert property (s_take ##0 (!i_protected &&
    i_request.opcode == 8'h8b && i_request.ea_offset == 16'hffff &&
    i_request.modrm[7:6] != 2'h3) |=> o_fault && !o_busy)
    else $error("overrun not refused");
  a_seg_load_count: assert property (s_take ##0 (i_protected &&
    i_request.opcode == 8'h8e && !i_request.three_elem) |=>
    o_decode.clocks == ($past(i_request.modrm[7:6]) == 2'h3 ? 5'h11
    : 5'h13)) else $error("segment load count");
  a_table_count: assert property (s_take ##0
    (i_request.opcode == 8'hd7) |=> o_decode.clocks == 5'h05 && !o_fault &&
    o_decode.writeback == dtd_pkg::DTD_WB_TABLE_BYTE)
    else $error("table lookup decode");
  a_ptr_reg_form: assert property (s_take ##0
    (i_request.opcode[7:1] == 7'h62 && i_request.modrm[7:6] == 2'h3) |=>
    o_undefined && !o_busy) else $error("pointer load register form");
  a_ptr_count: assert property (s_take ##0
    (i_request.opcode[7:1] == 7'h62) ##0 s_mem |=>
    o_decode.clocks == ($past(i_protected) ? 5'h15 : 5'h07))
    else $error("pointer load count");
  a_size_dir: assert property (s_take ##0
    (i_request.opcode[7:2] == 6'h22) |=>
    o_decode.word == $past(i_request.opcode[0]) &&
    o_decode.reg_is_dest == $past(i_request.opcode[1]))
    else $error("size or direction bit");
endmodule

bind dtd_decoder dtd_decoder_chk chk (.i_clock, .i_nrst, .i_valid,
  .i_request, .i_protected, .o_ready, .o_decode, .o_busy, .o_done,
  .o_fault, .o_fault_vector, .o_undefined);

// [verification/dtd_fetch_model.sv]
`timescale 1ns/100ps
// fetch side: offers one prefetched request after a chosen stall
module dtd_fetch_model (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire dtd_pkg::dtd_request_t i_next,
  input wire logic [3:0] i_stall,
  input wire logic i_ready,
  output logic o_valid,
  output dtd_pkg::dtd_request_t o_request,
  output logic o_taken
);
  logic valid_ff, armed_ff, taken_ff;
  logic [3:0] wait_ff;
  dtd_pkg::dtd_request_t hold_ff;
  // request held until taken, so a stalled decoder never loses it
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      valid_ff <= 1'b0;
      armed_ff <= 1'b0;
      taken_ff <= 1'b0;
      wait_ff <= 4'h0;
      hold_ff <= '0;
    end else begin
      taken_ff <= valid_ff && i_ready;
      if (valid_ff && i_ready) begin
        valid_ff <= 1'b0;
      end
      if (i_start) begin
        armed_ff <= 1'b1;
        wait_ff <= i_stall;
        hold_ff <= i_next;
      end else if (armed_ff && wait_ff != 4'h0) begin
        wait_ff <= wait_ff - 4'h1;
      end else if (armed_ff) begin
        armed_ff <= 1'b0;
        valid_ff <= 1'b1;
      end
    end
  end
  // lines show the inverse when nothing is offered, never a stale copy
  assign o_request = valid_ff ? hold_ff : ~hold_ff;
  assign o_valid = valid_ff;
  assign o_taken = taken_ff;
endmodule

// [verification/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic i_protected = 1'b0;
  logic start = 1'b0;
  logic [3:0] stall = 4'h0;
  dtd_pkg::dtd_request_t offer = '0;
  logic i_valid, o_ready, o_busy, o_done, o_fault, o_undefined, taken;
  logic [7:0] o_fault_vector;
  dtd_pkg::dtd_request_t i_request;
  dtd_pkg::dtd_decode_t o_decode;
  int n_errors = 0;
  int n_tests = 0;

  // 250 MHz processor clock
  always #2 i_clock = ~i_clock;

  dtd_fetch_model fetch (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_start(start), .i_next(offer), .i_stall(stall), .i_ready(o_ready),
    .o_valid(i_valid), .o_request(i_request), .o_taken(taken));
  dtd_decoder dut (.i_clock, .i_nrst, .i_valid, .i_request, .i_protected,
    .o_ready, .o_decode, .o_busy, .o_done, .o_fault, .o_fault_vector,
    .o_undefined);

  task automatic check(input logic [31:0] seen, input logic [31:0] want,
    input string what);
    n_tests++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  // one request through the fetch model; kind 0 runs, 1 faults, 2 undefined
  task automatic run(input logic [7:0] opc, input logic [7:0] mrm,
    input logic [15:0] off, input logic thr, input logic prot,
    input logic [3:0] st, input logic [1:0] kind, input logic [4:0] n);
    int k;
    @(posedge i_clock);
    i_protected <= prot;
    offer <= {opc, mrm, off, thr};
    stall <= st;
    start <= 1'b1;
    @(posedge i_clock);
    start <= 1'b0;
    k = 0;
    do begin
      @(posedge i_clock);
      #1;
      k++;
    end while (taken !== 1'b1 && k < 40);
    check(taken, 1'b1, "accept");
    check(o_fault, kind == 2'h1, "fault");
    check(o_fault_vector, kind == 2'h1 ? 8'h0d : 8'h00, "vector");
    check(o_undefined, kind == 2'h2, "undefined");
    if (kind == 2'h0) begin
      check(o_decode.clocks, n, "clocks");
      k = 0;
      while (o_busy === 1'b1 && k < 40) begin
        @(posedge i_clock);
        #1;
        k++;
      end
      check(k, n, "busy cycles");
      check(o_done, 1'b1, "done");
    end
  endtask

  task automatic t_seg_load;
    run(8'h8e, 8'hd8, 16'h0010, 1'b0, 1'b0, 4'h0, 2'h0, 5'h02);
    run(8'h8e, 8'h5e, 16'h0010, 1'b0, 1'b0, 4'h2, 2'h0, 5'h05);
    run(8'h8e, 8'hd8, 16'h0010, 1'b0, 1'b1, 4'h0, 2'h0, 5'h11);
    run(8'h8e, 8'h5e, 16'h0010, 1'b0, 1'b1, 4'h0, 2'h0, 5'h13);
    run(8'h8e, 8'h5e, 16'h0010, 1'b1, 1'b0, 4'h0, 2'h0, 5'h06);
    $display("segment load done");
  endtask

  task automatic t_seg_store;
    for (int p = 0; p < 2; p++) begin
      run(8'h8c, 8'hc0, 16'h0020, 1'b0, p[0], 4'h0, 2'h0, 5'h02);
      run(8'h8c, 8'h46, 16'h0020, 1'b0, p[0], 4'h0, 2'h0, 5'h03);
    end
    $display("segment store done");
  endtask

  task automatic t_table;
    for (int p = 0; p < 2; p++) begin
      run(8'hd7, 8'h00, 16'hffff, 1'b0, p[0], 4'h0, 2'h0, 5'h05);
      check(o_decode.writeback, dtd_pkg::DTD_WB_TABLE_BYTE, "wb");
      check(o_decode.reg_sel, 3'h0, "table dest");
      check(o_decode.word, 1'b0, "table byte");
    end
    $display("table lookup done");
  endtask

  task automatic t_eff_addr;
    run(8'h8d, 8'h46, 16'hffff, 1'b0, 1'b0, 4'h0, 2'h0, 5'h03);
    check(o_decode.writeback, dtd_pkg::DTD_WB_OFFSET, "wb");
    run(8'h8d, 8'h46, 16'h1234, 1'b1, 1'b1, 4'h0, 2'h0, 5'h04);
    $display("effective address done");
  endtask

  task automatic t_ptr_load;
    for (int p = 0; p < 2; p++) begin
      run(8'hc5, 8'h46, 16'h0040, 1'b0, p[0], 4'h0, 2'h0,
        p ? 5'h15 : 5'h07);
      check(o_decode.op, dtd_pkg::DTD_OP_POINTER_LOAD_FIRST, "op");
      check(o_decode.mem_operand, 1'b1, "memory");
      run(8'hc4, 8'h46, 16'h0040, 1'b0, p[0], 4'h0, 2'h0,
        p ? 5'h15 : 5'h07);
      check(o_decode.op, dtd_pkg::DTD_OP_POINTER_LOAD_EXTRA, "op");
    end
    run(8'hc5, 8'hc0, 16'hffff, 1'b0, 1'b0, 4'h0, 2'h2, 5'h00);
    run(8'hc4, 8'hc1, 16'h0040, 1'b0, 1'b1, 4'h0, 2'h2, 5'h00);
    $display("pointer load done");
  endtask

  task automatic t_size_dir;
    for (int i = 0; i < 4; i++) begin
      run(8'h88 | i[7:0], 8'hc1, 16'h0000, 1'b0, 1'b0, 4'h0, 2'h0, 5'h02);
      check(o_decode.word, i[0], "word");
      check(o_decode.reg_is_dest, i[1], "direction");
    end
    $display("size and direction done");
  endtask

  task automatic t_overrun;
    run(8'h8b, 8'h46, 16'hffff, 1'b0, 1'b0, 4'h0, 2'h1, 5'h00);
    check(o_ready, 1'b1, "ready after fault");
    run(8'h8e, 8'h5e, 16'hffff, 1'b0, 1'b0, 4'h0, 2'h1, 5'h00);
    run(8'h8a, 8'h46, 16'hffff, 1'b0, 1'b0, 4'h0, 2'h0, 5'h05);
    run(8'h8b, 8'h46, 16'hffff, 1'b0, 1'b1, 4'h0, 2'h0, 5'h05);
    run(8'h8b, 8'h46, 16'hfffe, 1'b0, 1'b0, 4'h5, 2'h0, 5'h05);
    $display("segment overrun done");
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // 28 requests of under 40 cycles each fit well inside this span
  initial begin
    repeat (5000) @(posedge i_clock);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    repeat (5) @(posedge i_clock);
    check(o_ready, 1'b1, "ready in reset");
    check(o_busy, 1'b0, "busy in reset");
    i_nrst <= 1'b1;
    t_seg_load();
    t_seg_store();
    t_table();
    t_eff_addr();
    t_ptr_load();
    t_size_dir();
    t_overrun();
    conclude();
  end
endmodule
